// file: design/gpb_regs.vh
// constants for the eight-pin general-purpose port block
`ifndef GPB_REGS_VH
`define GPB_REGS_VH
`define GPB_SEL_DIR    4'h0
`define GPB_SEL_SENSE  4'h1
`define GPB_SEL_BOTH   4'h2
`define GPB_SEL_EVENT  4'h3
`define GPB_SEL_MASK   4'h4
`define GPB_SEL_CLEAR  4'h5
`define GPB_SEL_ALT    4'h6
`define GPB_SEL_DRV2   4'h7
`define GPB_SEL_DRV4   4'h8
`define GPB_SEL_DRV8   4'h9
`define GPB_SEL_ODR    4'ha
`define GPB_SEL_PUR    4'hb
`define GPB_SEL_PDR    4'hc
`define GPB_SEL_SLR    4'hd
`define GPB_SEL_DEN    4'he
`define GPB_SEL_COMMIT 4'hf
`define GPB_ZERO8      8'h00
`define GPB_DRV2_RST   8'hff
`endif

// file: design/gpb_port.v
// one eight-pin general-purpose port: data, direction, interrupts, pads
`timescale 1ns/1ps
`include "gpb_regs.vh"
// one instance per port; parameters carry the per-port differences
module gpb_port #(
   parameter [7:0]  DEBUG_PINS  = 8'h00, // pins that default to the debug function
   parameter [7:0]  PIN_PRESENT = 8'hff, // pins with a pad behind them
   parameter [63:0] PERIPH_ID   = 64'h0000_0000_0011_2233, // arbitrary value
   parameter [31:0] CELL_ID     = 32'h4455_6677             // arbitrary value
) (
   input  wire       clk,
   input  wire       resetn,
   // masked data access
   input  wire       dat_we,
   input  wire       dat_re,
   input  wire [7:0] dat_addr_mask,
   input  wire [7:0] dat_wdata,
   output reg  [7:0] dat_rdata,
   // configuration writes
   input  wire       cfg_we,
   input  wire [3:0] cfg_sel,
   input  wire [7:0] cfg_wdata,
   input  wire       commit_lock,
   // identification
   input  wire [3:0] ident_index,
   output reg  [7:0] ident_data,
   // configuration and status views
   output reg  [7:0] pin_direction,
   output reg  [7:0] irq_sense_select,
   output reg  [7:0] irq_both_edges,
   output reg  [7:0] irq_event_polarity,
   output reg  [7:0] irq_mask,
   output wire [7:0] irq_raw_status,
   output wire [7:0] irq_masked_status,
   output wire       irq,
   output reg  [7:0] alt_function_select,
   output reg  [7:0] commit_enable,
   output reg  [7:0] drive_low_select,
   output reg  [7:0] drive_mid_select,
   output reg  [7:0] drive_high_select,
   output reg  [7:0] open_drain_select,
   output reg  [7:0] pull_up_select,
   output reg  [7:0] pull_down_select,
   output reg  [7:0] slew_control_select,
   output reg  [7:0] digital_input_enable,
   // pads
   input  wire [7:0] pad_in,
   output wire [7:0] pad_out,
   output wire [7:0] pad_oe,
   // alternate-function peripheral side
   input  wire [7:0] alt_out,
   input  wire [7:0] alt_oe,
   output wire [7:0] alt_in
);

   reg  [7:0] pin_value_q;
   reg  [7:0] sync1_q;
   reg  [7:0] sync2_q;
   reg  [7:0] prev_q;
   reg  [7:0] edge_q;
   wire [7:0] rise;
   wire [7:0] fall;
   wire [7:0] edge_hit;
   wire [7:0] level_hit;
   wire [7:0] clr;
   wire [7:0] gpio_oe;
   wire [7:0] gpio_out;
   wire       unlocked;
   wire [7:0] alt_writable;

   // a write selected by code, limited to bonded pins
   function [7:0] cfg_hit;
      input [3:0] sel;
      begin
         cfg_hit = (cfg_we && cfg_sel == sel) ? PIN_PRESENT : `GPB_ZERO8;
      end
   endfunction

   // one drive-strength select: own write lands, a sibling's set bits clear it
   function [7:0] drive_next;
      input [7:0] cur;
      input [7:0] own;
      input [7:0] other_a;
      input [7:0] other_b;
      input [7:0] data;
      begin
         drive_next = ((cur & ~(own & ~data)) | (own & data))
                      & ~((other_a | other_b) & data);
      end
   endfunction

   // merge a write into a register under a bit mask
   function [7:0] merge;
      input [7:0] old;
      input [7:0] data;
      input [7:0] en;
      begin
         merge = (old & ~en) | (data & en);
      end
   endfunction

   // two-flop synchroniser; first stage feeds the second only
   always @(posedge clk) begin
      if (!resetn) begin
         sync1_q <= `GPB_ZERO8;
         sync2_q <= `GPB_ZERO8;
         prev_q  <= `GPB_ZERO8;
      end else begin
         sync1_q <= pad_in;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   assign alt_in = sync2_q & digital_input_enable;

   // edge and level detection
   assign rise      = sync2_q & ~prev_q;
   assign fall      = ~sync2_q & prev_q;
   assign edge_hit  = irq_both_edges & (rise | fall) |
                      ~irq_both_edges & (irq_event_polarity & rise |
                      ~irq_event_polarity & fall);
   assign level_hit = irq_event_polarity & sync2_q |
                      ~irq_event_polarity & ~sync2_q;
   assign clr       = cfg_hit(`GPB_SEL_CLEAR) & cfg_wdata;

   // latched edge events; a new edge beats a clear in the same cycle
   always @(posedge clk) begin
      if (!resetn) begin
         edge_q <= `GPB_ZERO8;
      end else begin
         edge_q <= (edge_q & ~clr) | (edge_hit & PIN_PRESENT);
      end
   end

   // level pins follow the pad; the source must hold it
   assign irq_raw_status    = irq_sense_select & level_hit & PIN_PRESENT |
                              ~irq_sense_select & edge_q;
   assign irq_masked_status = irq_raw_status & irq_mask;
   assign irq               = |irq_masked_status;

   // commit protection on alternate select
   assign unlocked     = ~commit_lock;
   assign alt_writable = ~DEBUG_PINS | (commit_enable & {8{unlocked}});

   // direction: 0 input, 1 output; reset leaves every pin an input
   always @(posedge clk) begin
      if (!resetn) begin
         pin_direction <= `GPB_ZERO8;
      end else begin
         pin_direction <= merge(pin_direction, cfg_wdata,
                                cfg_hit(`GPB_SEL_DIR));
      end
   end

   // trigger sense; changes on unmasked pins may fire once
   always @(posedge clk) begin
      if (!resetn) begin
         irq_sense_select <= `GPB_ZERO8;
      end else begin
         irq_sense_select <= merge(irq_sense_select, cfg_wdata,
                                   cfg_hit(`GPB_SEL_SENSE));
      end
   end

   // both-edges select; overrides polarity for edge pins
   always @(posedge clk) begin
      if (!resetn) begin
         irq_both_edges <= `GPB_ZERO8;
      end else begin
         irq_both_edges <= merge(irq_both_edges, cfg_wdata,
                                 cfg_hit(`GPB_SEL_BOTH));
      end
   end

   // event polarity: high/rising or low/falling
   always @(posedge clk) begin
      if (!resetn) begin
         irq_event_polarity <= `GPB_ZERO8;
      end else begin
         irq_event_polarity <= merge(irq_event_polarity, cfg_wdata,
                                     cfg_hit(`GPB_SEL_EVENT));
      end
   end

   // interrupt mask; only gates forwarding, the latch keeps running
   always @(posedge clk) begin
      if (!resetn) begin
         irq_mask <= `GPB_ZERO8;
      end else begin
         irq_mask <= merge(irq_mask, cfg_wdata,
                           cfg_hit(`GPB_SEL_MASK));
      end
   end

   // alternate select; debug pins guarded by lock and commit
   always @(posedge clk) begin
      if (!resetn) begin
         alt_function_select <= DEBUG_PINS;
      end else begin
         alt_function_select <= merge(alt_function_select, cfg_wdata,
                                      cfg_hit(`GPB_SEL_ALT) & alt_writable);
      end
   end

   // commit bits; writable only for debug pins while unlocked
   // ordinary pins stay committable; their select bypasses commit_enable and is never blocked
   always @(posedge clk) begin
      if (!resetn) begin
         commit_enable <= ~DEBUG_PINS;
      end else begin
         commit_enable <= merge(commit_enable, cfg_wdata,
                                cfg_hit(`GPB_SEL_COMMIT) & DEBUG_PINS & {8{unlocked}});
      end
   end

   // drive strengths exclusive per pin: setting one clears the others
   // low drive is the reset choice so every pin comes out of reset with one strength
   always @(posedge clk) begin
      if (!resetn) begin
         drive_low_select <= `GPB_DRV2_RST;
      end else begin
         drive_low_select <= drive_next(drive_low_select, cfg_hit(`GPB_SEL_DRV2),
                                        cfg_hit(`GPB_SEL_DRV4), cfg_hit(`GPB_SEL_DRV8),
                                        cfg_wdata);
      end
   end

   // middle drive strength
   always @(posedge clk) begin
      if (!resetn) begin
         drive_mid_select <= `GPB_ZERO8;
      end else begin
         drive_mid_select <= drive_next(drive_mid_select, cfg_hit(`GPB_SEL_DRV4),
                                        cfg_hit(`GPB_SEL_DRV2), cfg_hit(`GPB_SEL_DRV8),
                                        cfg_wdata);
      end
   end

   // high drive strength
   always @(posedge clk) begin
      if (!resetn) begin
         drive_high_select <= `GPB_ZERO8;
      end else begin
         drive_high_select <= drive_next(drive_high_select, cfg_hit(`GPB_SEL_DRV8),
                                         cfg_hit(`GPB_SEL_DRV2), cfg_hit(`GPB_SEL_DRV4),
                                         cfg_wdata);
      end
   end

   // open drain enable
   always @(posedge clk) begin
      if (!resetn) begin
         open_drain_select <= `GPB_ZERO8;
      end else begin
         open_drain_select <= merge(open_drain_select, cfg_wdata,
                                    cfg_hit(`GPB_SEL_ODR));
      end
   end

   // weak pull-up; debug pins come up pulled
   always @(posedge clk) begin
      if (!resetn) begin
         pull_up_select <= DEBUG_PINS;
      end else begin
         pull_up_select <= merge(pull_up_select, cfg_wdata,
                                 cfg_hit(`GPB_SEL_PUR));
      end
   end

   // weak pull-down
   always @(posedge clk) begin
      if (!resetn) begin
         pull_down_select <= `GPB_ZERO8;
      end else begin
         pull_down_select <= merge(pull_down_select, cfg_wdata,
                                   cfg_hit(`GPB_SEL_PDR));
      end
   end

   // slew control; only meaningful with high drive
   always @(posedge clk) begin
      if (!resetn) begin
         slew_control_select <= `GPB_ZERO8;
      end else begin
         slew_control_select <= merge(slew_control_select, cfg_wdata,
                                      cfg_hit(`GPB_SEL_SLR));
      end
   end

   // digital input enable; off keeps floating pads out of the data register and alt_in, not out of the interrupt detection
   always @(posedge clk) begin
      if (!resetn) begin
         digital_input_enable <= DEBUG_PINS;
      end else begin
         digital_input_enable <= merge(digital_input_enable, cfg_wdata,
                                       cfg_hit(`GPB_SEL_DEN));
      end
   end

   // data register: inputs capture the pad, outputs keep masked writes
   always @(posedge clk) begin
      if (!resetn) begin
         pin_value_q <= `GPB_ZERO8;
      end else begin
         pin_value_q <= (~pin_direction & sync2_q & digital_input_enable & PIN_PRESENT)
                        | (pin_direction & merge(pin_value_q, dat_wdata,
                           dat_we ? dat_addr_mask & PIN_PRESENT : `GPB_ZERO8));
      end
   end

   // masked read, registered
   always @(posedge clk) begin
      if (!resetn) begin
         dat_rdata <= `GPB_ZERO8;
      end else if (dat_re) begin
         dat_rdata <= pin_value_q & dat_addr_mask;
      end
   end

   // identification bytes, fixed constants
   always @(posedge clk) begin
      if (!resetn) begin
         ident_data <= `GPB_ZERO8;
      end else if (ident_index[3]) begin
         ident_data <= CELL_ID[ident_index[1:0]*8 +: 8];
      end else begin
         ident_data <= PERIPH_ID[ident_index[2:0]*8 +: 8];
      end
   end

   // pad drive; open drain only ever pulls low on pins the alternate function does not own
   assign gpio_out = pin_value_q & ~open_drain_select;
   assign gpio_oe  = pin_direction & ~(open_drain_select & pin_value_q);
   assign pad_out  = PIN_PRESENT & (alt_function_select & alt_out |
                     ~alt_function_select & gpio_out);
   assign pad_oe   = PIN_PRESENT & (alt_function_select & alt_oe |
                     ~alt_function_select & gpio_oe);

endmodule // gpb_port

// file: sim/gpb_port_properties.sv
// assertion checker for the eight-pin port block
`timescale 1ns/1ps
`include "gpb_regs.vh"
module gpb_port_properties #(
   parameter [7:0] DEBUG_PINS = 8'h00
) (
   input wire       clk,
   input wire       resetn,
   input wire       dat_re,
   input wire [7:0] dat_addr_mask,
   input wire [7:0] dat_rdata,
   input wire       cfg_we,
   input wire [3:0] cfg_sel,
   input wire [7:0] pin_direction,
   input wire [7:0] irq_sense_select,
   input wire [7:0] irq_mask,
   input wire [7:0] irq_raw_status,
   input wire [7:0] irq_masked_status,
   input wire       irq,
   input wire [7:0] alt_function_select,
   input wire [7:0] commit_enable,
   input wire [7:0] open_drain_select,
   input wire [7:0] pad_oe,
   input wire [7:0] alt_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // pad drive follows direction unless a peripheral or open drain owns it
   property p_drive;
      (pad_oe | ~pin_direction | alt_function_select | open_drain_select) == 8'hff;
   endproperty
   a_drive: assert property (p_drive) else $error("output pin not driven");
   property p_input;
      (pad_oe & ~pin_direction & ~alt_function_select & ~open_drain_select) == 8'h00;
   endproperty
   a_input: assert property (p_input) else $error("input pin driven");
   property p_read;
      dat_re |=> (dat_rdata & ~$past(dat_addr_mask)) == 8'h00;
   endproperty
   a_read: assert property (p_read) else $error("unselected read bit set");
   property p_irq;
      irq == (irq_masked_status != 8'h00);
   endproperty
   a_irq: assert property (p_irq) else $error("irq line not the or of pins");
   property p_masked;
      irq_masked_status == (irq_raw_status & irq_mask);
   endproperty
   a_masked: assert property (p_masked) else $error("masked status wrong");
   property p_alt;
      ((pad_oe ^ alt_oe) & alt_function_select & ~open_drain_select) == 8'h00;
   endproperty
   a_alt: assert property (p_alt) else $error("peripheral not owning pad");
   property p_reset;
      $rose(resetn) |-> alt_function_select == DEBUG_PINS && commit_enable == ~DEBUG_PINS;
   endproperty
   a_reset: assert property (p_reset) else $error("reset defaults wrong");
   // a latched edge may only fall through a clear or a sense change
   property p_hold;
      !(cfg_we && (cfg_sel == `GPB_SEL_CLEAR || cfg_sel == `GPB_SEL_SENSE))
      |=> (~$past(irq_raw_status & ~irq_sense_select) | irq_raw_status) == 8'hff;
   endproperty
   a_hold: assert property (p_hold) else $error("edge latch lost");
   c_irq: cover property ($rose(irq));
   c_read: cover property (dat_re && dat_addr_mask != 8'h00);
   c_clear: cover property (cfg_we && cfg_sel == `GPB_SEL_CLEAR && irq_raw_status != 8'h00);
endmodule // gpb_port_properties
bind gpb_port gpb_port_properties #(.DEBUG_PINS(DEBUG_PINS)) i_gpb_port_properties (.*);

// file: sim/gpb_pad_model.sv
// pad ring model: level seen back on each pin
`timescale 1ns/1ps
module gpb_pad_model (
   input  wire [7:0] pad_out,
   input  wire [7:0] pad_oe,
   input  wire [7:0] ext_level,
   output wire [7:0] pad_in
);
   // port drive wins; the outside source holds its level steady otherwise
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule // gpb_pad_model

// file: sim/gpb_port_test.sv
// self-checking bench for the port block
`timescale 1ns/1ps
`include "gpb_regs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module gpb_port_test;
   localparam [7:0]  DBG = 8'h0f;
   localparam [63:0] PID = 64'h0123_4567_89ab_cdef; // arbitrary value
   localparam [31:0] CID = 32'h5a5a_c3c3;            // arbitrary value
   localparam [19:0] MODES = 20'h304b8; // sense, both, event, active level
   reg        clk, resetn, dat_we, dat_re, cfg_we, commit_lock;
   reg  [3:0] cfg_sel, ident_index;
   reg  [7:0] dat_addr_mask, dat_wdata, cfg_wdata, alt_out, alt_oe, ext_level, v, m, x;
   wire [7:0] dat_rdata, ident_data, pin_direction, irq_sense_select, irq_both_edges;
   wire [7:0] irq_event_polarity, irq_mask, irq_raw_status, irq_masked_status;
   wire [7:0] alt_function_select, commit_enable, drive_low_select, drive_mid_select;
   wire [7:0] drive_high_select, open_drain_select, pull_up_select, pull_down_select;
   wire [7:0] slew_control_select, digital_input_enable, pad_in, pad_out, pad_oe, alt_in;
   wire       irq;
   wire [63:0] pv = {digital_input_enable, slew_control_select, pull_down_select,
      pull_up_select, open_drain_select, drive_high_select, drive_mid_select, drive_low_select};
   int        errors = 0, tests_run = 0, cycles = 0, i;
   gpb_port #(.DEBUG_PINS(DBG), .PIN_PRESENT(8'h7f), .PERIPH_ID(PID), .CELL_ID(CID))
      i_gpb_port (.*);
   gpb_pad_model i_gpb_pad_model (.*);
   always #10 clk = ~clk;
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         errors++;
         final_report;
      end
   end
   function [7:0] mwr(input [7:0] o, input [7:0] mk, input [7:0] d);
      mwr = (o & ~mk) | (d & mk);
   endfunction
   task final_report;
      if (errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // strobes drop for a full cycle so back-to-back calls never retoggle at one instant
   task cfg(input [3:0] s, input [7:0] d);
      cfg_sel = s;
      cfg_wdata = d;
      cfg_we = 1'h1;
      @(negedge clk);
      cfg_we = 1'h0;
      @(negedge clk);
   endtask
   task dat(input w, input [7:0] mk, input [7:0] d);
      dat_addr_mask = mk;
      dat_wdata = d;
      dat_we = w;
      dat_re = !w;
      @(negedge clk);
      dat_we = 1'h0;
      dat_re = 1'h0;
      @(negedge clk);
   endtask
   initial begin
      {clk, resetn, dat_we, dat_re, cfg_we, cfg_sel, ident_index} = '0;
      {dat_addr_mask, dat_wdata, cfg_wdata, alt_out, alt_oe, ext_level} = '0;
      commit_lock = 1'h1;
      x = $urandom(32219);
      repeat (16) @(negedge clk);
      resetn = 1'h1;
      `CHK("alt", DBG, alt_function_select)
      `CHK("pullup", DBG, pull_up_select)
      `CHK("dien", DBG, digital_input_enable)
      `CHK("pulldn", 8'h00, pull_down_select)
      `CHK("commit", ~DBG, commit_enable)
      for (i = 7; i < 15; i++) begin
         x = $urandom;
         cfg(i[3:0], x);
         `CHK("pad cfg", (x & 8'h7f) | (i == 7 ? 8'h80 : 8'h00), pv[8*(i-7) +: 8])
      end
      cfg(`GPB_SEL_ODR, 8'h00);
      cfg(`GPB_SEL_DEN, 8'hff);
      cfg(`GPB_SEL_DIR, 8'hf0);
      `CHK("dir", 8'h70, pin_direction)
      v = 8'h00;
      for (i = 0; i < 24; i++) begin
         m = i ? $urandom : 8'h26;
         x = i ? $urandom : 8'heb;
         dat(1'h1, m, x);
         v = mwr(v, m, x);
         `CHK("pad out", v & 8'h70, pad_out & 8'h70)
         m = $urandom;
         dat(1'h0, m, 8'h00);
         `CHK("read", v & m & 8'h70, dat_rdata & 8'h70)
      end
      cfg(`GPB_SEL_ODR, 8'h70);
      `CHK("od oe", ~v & 8'h70, pad_oe & 8'h70)
      `CHK("od out", 8'h00, pad_out & 8'h70)
      cfg(`GPB_SEL_ODR, 8'h00);
      cfg(`GPB_SEL_DIR, 8'h00);
      for (i = 0; i < 8; i++) begin
         ext_level = $urandom;
         repeat (4) @(negedge clk);
         `CHK("alt in", ext_level & 8'h7f, alt_in)
         m = $urandom;
         dat(1'h0, m, 8'h00);
         `CHK("capture", ext_level & m & 8'h70, dat_rdata & 8'h70)
      end
      // every trigger kind on pin 4, armed only while masked
      for (i = 0; i < 5; i++) begin
         x = MODES[4*i +: 4];
         cfg(`GPB_SEL_MASK, 8'h00);
         cfg(`GPB_SEL_SENSE, {3'h0, x[3], 4'h0});
         cfg(`GPB_SEL_BOTH, {3'h0, x[2], 4'h0});
         cfg(`GPB_SEL_EVENT, {3'h0, x[1], 4'h0});
         ext_level = {3'h0, ~x[0], 4'h0};
         repeat (5) @(negedge clk);
         cfg(`GPB_SEL_CLEAR, 8'h10);
         `CHK("idle raw", 8'h00, irq_raw_status & 8'h10)
         cfg(`GPB_SEL_MASK, 8'h10);
         ext_level = {3'h0, x[0], 4'h0};
         repeat (5) @(negedge clk);
         `CHK("raw", 8'h10, irq_raw_status & 8'h10)
         `CHK("masked", 8'h10, irq_masked_status)
         `CHK("irq", 1'h1, irq)
         cfg(`GPB_SEL_MASK, 8'h00);
         `CHK("irq off", 1'h0, irq)
         cfg(`GPB_SEL_CLEAR, 8'hef);
         ext_level = {3'h0, ~x[0], 4'h0};
         repeat (5) @(negedge clk);
         `CHK("held", {3'h0, ~x[3], 4'h0}, irq_raw_status & 8'h10)
         cfg(`GPB_SEL_CLEAR, 8'h10);
         `CHK("cleared", 8'h00, irq_raw_status & 8'h10)
      end
      cfg(`GPB_SEL_ALT, 8'h30);
      `CHK("alt locked", 8'h3f, alt_function_select)
      commit_lock = 1'h0;
      cfg(`GPB_SEL_COMMIT, 8'h01);
      `CHK("commit", 8'hf1, commit_enable)
      cfg(`GPB_SEL_ALT, 8'h30);
      `CHK("alt open", 8'h3e, alt_function_select)
      for (i = 0; i < 4; i++) begin
         alt_out = $urandom;
         alt_oe = $urandom;
         @(negedge clk);
         `CHK("alt oe", alt_oe & 8'h30, pad_oe & 8'h30)
         `CHK("alt out", alt_out & alt_oe & 8'h30, pad_out & pad_oe & 8'h30)
      end
      for (i = 0; i < 12; i++) begin
         ident_index = i[3:0];
         @(negedge clk);
         `CHK("ident", i < 8 ? PID[8*i +: 8] : CID[8*(i-8) +: 8], ident_data)
      end
      resetn = 1'h0;
      repeat (2) @(negedge clk);
      resetn = 1'h1;
      `CHK("alt again", DBG, alt_function_select)
      `CHK("dir again", 8'h00, pin_direction)
      final_report;
   end
endmodule // gpb_port_test
